// [shared/cf_consts.svh]
// Offsets, fields, reset values and limits of the channel coefficient filter.
// Assumes inclusion from the design file and the bench only.
`ifndef CF_CONSTS_SVH
`define CF_CONSTS_SVH
`define CF_OFF_CTRL 8'h00
`define CF_OFF_TAPS 8'h04
`define CF_OFF_COFS 8'h08
`define CF_OFF_START 8'h0c
`define CF_OFF_STOP 8'h10
`define CF_OFF_MEM 8'h14
`define CF_OFF_STAT 8'h18
`define CF_CTRL_RATE_LSB 0
`define CF_CTRL_PHASE_LSB 4
`define CF_CTRL_SCALE_LSB 8
`define CF_CTRL_SYM_BIT 10
`define CF_CTRL_BYP_BIT 11
`define CF_CTRL_NARROW_BIT 12
`define CF_CTRL_RST 13'h0300
`define CF_TAPS_RST 7'h00
`define CF_HIST_DEPTH 144
`define CF_SAT_POS 48'sh0000_0007_ffff
`define CF_SAT_NEG -48'sh0000_0008_0000
`define CF_SCALE_BASE 6'd22
`endif

// [shared/cf_pkg.sv]
// Types of the channel coefficient filter.
// Assumes the constants header is compiled alongside.
`default_nettype none
package cf_pkg;
  typedef enum logic [1:0] {CF_IDLE, CF_RUN, CF_DONE} cf_state_t;
endpackage : cf_pkg
`default_nettype wire

// [hdl/cf_channel_coeff_filter.sv]
// Decimating complex FIR stage with coefficient RAM and APB registers.
// Assumes samples arrive on pclk as one-cycle valid pulses; pclk is the fast processing clock.
`timescale 1ns/1ps
`default_nettype none
`include "cf_consts.svh"

// Behaviour
// - Samples and coefficients are 20 bit; I and Q use the RAM coefficients.
// - Up to 64 stored taps, 128 taps when symmetric.
// - Tap register holds taps minus one.
// - Four-bit decimation field holds factor minus one, factors 1 to 16.
// - One output per decimation factor input samples while phase is below the factor.
// - Bypass passes input to output unchanged, unscaled.
// - Scale 00 divides by eight, 01 by four, 10 by two, 11 none.
// - Symmetric mode reads only half the impulse response from RAM.
// - Coefficient offset selects the RAM region in use.
// - Offset change mid-sample applies from the next output sample.
// - Four-bit phase field sets which input slot fires the output.
// - One I and one Q multiplier, one tap per clock.
// - Narrow port moves low byte first; word commits after the high part.
// - Wide port moves low 16 bits, then the top four.
// - Start address sets the first RAM word reached by the port.
// - Stop address sets the last RAM word reached by the port.
// - Each port word access advances the pointer from start to stop.
// - Equal start and stop keep every access on one RAM word.
module cf_channel_coeff_filter
  import cf_pkg::*;
#(
  parameter int HIST_DEPTH = `CF_HIST_DEPTH
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic in_valid,
  input wire logic [19:0] in_i,
  input wire logic [19:0] in_q,
  output logic out_valid,
  output logic [19:0] out_i,
  output logic [19:0] out_q
);
  localparam int HD = HIST_DEPTH;

  // 128 symmetric taps need 128 entries; the history index is only 8 bits
  if (HD < 128 || HD > 255) begin : g_depth_chk
    $error("history depth out of range");
  end

  logic [12:0] ctrl_reg;
  logic [6:0] taps_reg;
  logic [5:0] cofs_reg;
  logic [5:0] start_reg;
  logic [5:0] stop_reg;
  logic [5:0] ptr_reg;
  logic [1:0] part_reg;
  logic [15:0] hold_reg;
  logic [19:0] cram [0:63];
  logic signed [19:0] hist_i [0:HD-1];
  logic signed [19:0] hist_q [0:HD-1];
  cf_state_t st_reg;
  logic [3:0] dec_reg;
  logic [6:0] j_reg;
  logic [6:0] tl_lat;
  logic [5:0] ofs_lat;
  logic sym_lat;
  logic [1:0] sc_lat;
  logic [4:0] sh_reg;
  logic signed [47:0] acc_i;
  logic signed [47:0] acc_q;

  logic [3:0] rate;
  logic [3:0] phase;
  logic [1:0] scale;
  logic sym;
  logic byp;
  logic narrow;
  assign rate = ctrl_reg[`CF_CTRL_RATE_LSB +: 4];
  assign phase = ctrl_reg[`CF_CTRL_PHASE_LSB +: 4];
  assign scale = ctrl_reg[`CF_CTRL_SCALE_LSB +: 2];
  assign sym = ctrl_reg[`CF_CTRL_SYM_BIT];
  assign byp = ctrl_reg[`CF_CTRL_BYP_BIT];
  assign narrow = ctrl_reg[`CF_CTRL_NARROW_BIT];

  function automatic logic [5:0] cf_caddr(input logic [6:0] j, input logic [6:0] tl,
                                          input logic sy, input logic [5:0] off);
    logic [7:0] half;
    logic [7:0] m;
    half = ({1'b0, tl} + 8'h01) >> 1;
    if (!sy)
      m = {1'b0, tl - j};
    else if ({1'b0, j} >= half)
      m = {1'b0, j} - half;
    else
      m = {1'b0, tl - j} - half;
    return off + m[5:0];
  endfunction : cf_caddr

  function automatic logic signed [47:0] cf_mac(input logic signed [47:0] a,
                                                input logic signed [19:0] s,
                                                input logic signed [19:0] c);
    logic signed [39:0] p;
    p = s * c;
    return a + {{8{p[39]}}, p};
  endfunction : cf_mac

  function automatic logic [19:0] cf_scale(input logic signed [47:0] a, input logic [1:0] sc);
    logic signed [47:0] v;
    v = a >>> (`CF_SCALE_BASE - {4'h0, sc});
    if (v > `CF_SAT_POS)
      return 20'h7ffff;
    else if (v < `CF_SAT_NEG)
      return 20'h80000;
    else
      return v[19:0];
  endfunction : cf_scale

  // APB: one wait state so read data comes from a flop
  logic acc_ph;
  logic hit;
  logic mem_hit;
  logic last_part;
  logic commit;
  assign acc_ph = psel & penable & pready;
  assign mem_hit = paddr == `CF_OFF_MEM;
  assign hit = mem_hit | paddr == `CF_OFF_CTRL | paddr == `CF_OFF_TAPS | paddr == `CF_OFF_COFS
             | paddr == `CF_OFF_START | paddr == `CF_OFF_STOP | paddr == `CF_OFF_STAT;
  assign last_part = part_reg == (narrow ? 2'd2 : 2'd1);
  assign commit = acc_ph & mem_hit & last_part;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~hit;
    end
  end

  logic [19:0] cur;
  assign cur = cram[ptr_reg];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel & penable & ~pready & ~pwrite) begin
      case (paddr)
        `CF_OFF_CTRL: prdata <= {19'h0, ctrl_reg};
        `CF_OFF_TAPS: prdata <= {25'h0, taps_reg};
        `CF_OFF_COFS: prdata <= {26'h0, cofs_reg};
        `CF_OFF_START: prdata <= {26'h0, start_reg};
        `CF_OFF_STOP: prdata <= {26'h0, stop_reg};
        `CF_OFF_MEM: begin
          if (narrow)
            prdata <= {24'h0, part_reg == 2'd0 ? cur[7:0] :
                              part_reg == 2'd1 ? cur[15:8] : {4'h0, cur[19:16]}};
          else
            prdata <= {16'h0, part_reg == 2'd0 ? cur[15:0] : {12'h0, cur[19:16]}};
        end
        `CF_OFF_STAT: prdata <= {22'h0, part_reg, ptr_reg, st_reg != CF_IDLE, 1'b0};
        default: prdata <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `CF_CTRL_RST;
      taps_reg <= `CF_TAPS_RST;
      cofs_reg <= 6'h00;
      start_reg <= 6'h00;
      stop_reg <= 6'h00;
    end else if (acc_ph & pwrite) begin
      case (paddr)
        `CF_OFF_CTRL: ctrl_reg <= pwdata[12:0];
        `CF_OFF_TAPS: taps_reg <= pwdata[6:0];
        `CF_OFF_COFS: cofs_reg <= pwdata[5:0];
        `CF_OFF_START: start_reg <= pwdata[5:0];
        `CF_OFF_STOP: stop_reg <= pwdata[5:0];
        default: ;
      endcase
    end
  end

  // Port pointer: any word access moves it; writing start reloads it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_reg <= 6'h00;
      part_reg <= 2'd0;
    end else if (acc_ph & pwrite & (paddr == `CF_OFF_START || paddr == `CF_OFF_CTRL)) begin
      if (paddr == `CF_OFF_START)
        ptr_reg <= pwdata[5:0];
      part_reg <= 2'd0;
    end else if (acc_ph & mem_hit) begin
      if (last_part) begin
        part_reg <= 2'd0;
        ptr_reg <= (ptr_reg == stop_reg) ? start_reg : ptr_reg + 6'd1;
      end else begin
        part_reg <= part_reg + 2'd1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_reg <= 16'h0;
    end else if (acc_ph & mem_hit & pwrite & ~last_part) begin
      if (!narrow)
        hold_reg <= pwdata[15:0];
      else if (part_reg == 2'd0)
        hold_reg[7:0] <= pwdata[7:0];
      else
        hold_reg[15:8] <= pwdata[7:0];
    end
  end

  // RAM has no reset: contents are undefined until loaded
  always_ff @(posedge pclk) begin
    if (commit & pwrite)
      cram[ptr_reg] <= {narrow ? pwdata[3:0] : pwdata[3:0], hold_reg};
  end

  // Delay line: index 0 is the newest sample
  always_ff @(posedge pclk) begin
    if (in_valid) begin
      hist_i[0] <= in_i;
      hist_q[0] <= in_q;
      for (int k = 1; k < HD; k++) begin
        hist_i[k] <= hist_i[k-1];
        hist_q[k] <= hist_q[k-1];
      end
    end
  end

  logic fire;
  assign fire = in_valid & ~byp & dec_reg == phase;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      dec_reg <= 4'h0;
    else if (in_valid & ~byp)
      dec_reg <= (dec_reg >= rate) ? 4'h0 : dec_reg + 4'h1;
  end

  // Shifts during a run move the taps deeper; the count keeps indices aligned
  logic [7:0] sidx;
  logic [5:0] caddr;
  assign sidx = {1'b0, j_reg} + {3'h0, sh_reg} + {7'h0, in_valid & st_reg == CF_RUN};
  assign caddr = cf_caddr(j_reg, tl_lat, sym_lat, ofs_lat);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= CF_IDLE;
      j_reg <= 7'h0;
      tl_lat <= 7'h0;
      ofs_lat <= 6'h0;
      sym_lat <= 1'b0;
      sc_lat <= 2'd3;
      sh_reg <= 5'h0;
      acc_i <= 48'sh0;
      acc_q <= 48'sh0;
    end else begin
      case (st_reg)
        CF_IDLE: begin
          // Fire while busy is lost: host keeps taps within budget
          if (fire) begin
            st_reg <= CF_RUN;
            j_reg <= 7'h0;
            sh_reg <= 5'h0;
            tl_lat <= taps_reg;
            ofs_lat <= cofs_reg;
            sym_lat <= sym;
            sc_lat <= scale;
            acc_i <= 48'sh0;
            acc_q <= 48'sh0;
          end
        end
        CF_RUN: begin
          if (in_valid && sh_reg != 5'h1f)
            sh_reg <= sh_reg + 5'h1;
          if (sidx < 8'(HD)) begin
            acc_i <= cf_mac(acc_i, hist_i[sidx], cram[caddr]);
            acc_q <= cf_mac(acc_q, hist_q[sidx], cram[caddr]);
          end
          if (j_reg == tl_lat)
            st_reg <= CF_DONE;
          else
            j_reg <= j_reg + 7'h1;
        end
        CF_DONE: st_reg <= CF_IDLE;
        default: st_reg <= CF_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid <= 1'b0;
      out_i <= 20'h0;
      out_q <= 20'h0;
    end else if (byp & in_valid) begin
      out_valid <= 1'b1;
      out_i <= in_i;
      out_q <= in_q;
    end else if (st_reg == CF_DONE) begin
      out_valid <= 1'b1;
      out_i <= cf_scale(acc_i, sc_lat);
      out_q <= cf_scale(acc_q, sc_lat);
    end else begin
      out_valid <= 1'b0;
    end
  end

  AST_BYPASS: assert property (@(posedge pclk) disable iff (!presetn)
    byp && in_valid |=> out_valid && out_i == $past(in_i) && out_q == $past(in_q))
    else $error("bypass did not pass sample");

  AST_FIRE: assert property (@(posedge pclk) disable iff (!presetn)
    st_reg == CF_IDLE && fire |=> st_reg == CF_RUN && j_reg == 7'h0)
    else $error("phase slot did not start a run");

  AST_DEC_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
    in_valid && !byp && dec_reg == rate && $stable(rate) |=> dec_reg == 4'h0)
    else $error("decimation counter did not wrap");

  AST_RUN_LEN: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(st_reg == CF_RUN) && tl_lat == 7'd3 |-> (st_reg == CF_RUN)[*4] ##1 st_reg == CF_DONE)
    else $error("four taps did not take four cycles");

  AST_OFS_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    st_reg == CF_RUN |=> $stable(ofs_lat) && $stable(tl_lat))
    else $error("offset changed during a run");

  AST_OFS_LATCH: assert property (@(posedge pclk) disable iff (!presetn)
    st_reg == CF_IDLE && fire |=> ofs_lat == $past(cofs_reg) && tl_lat == $past(taps_reg))
    else $error("run did not latch offset and taps");

  AST_PTR_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
    commit && ptr_reg == stop_reg |=> ptr_reg == $past(start_reg))
    else $error("pointer did not return to start");

  AST_PTR_INC: assert property (@(posedge pclk) disable iff (!presetn)
    commit && ptr_reg != stop_reg |=> ptr_reg == $past(ptr_reg) + 6'd1)
    else $error("pointer did not advance");

  AST_PART_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    acc_ph && mem_hit && !last_part |=> $stable(ptr_reg) && part_reg != 2'd0)
    else $error("pointer moved before the last part");

  AST_OUT_DONE: assert property (@(posedge pclk) disable iff (!presetn)
    st_reg == CF_DONE && !byp |=> out_valid ##1 !out_valid || (byp && $past(in_valid)))
    else $error("filter output not a single pulse");

  AST_PREADY: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer not one wait state");

  COV_RUN: cover property (@(posedge pclk) disable iff (!presetn) st_reg == CF_DONE);
  COV_SYM: cover property (@(posedge pclk) disable iff (!presetn) st_reg == CF_RUN && sym_lat);
  COV_WRAP: cover property (@(posedge pclk) disable iff (!presetn) commit && ptr_reg == stop_reg);
  COV_BYP: cover property (@(posedge pclk) disable iff (!presetn) byp && in_valid);
endmodule : cf_channel_coeff_filter
`default_nettype wire

// [sim/cf_upstream_src.sv]
// Model of the upstream decimating stage: one I/Q sample per call.
// Assumes pclk domain; the bench sets the spacing between samples.
`timescale 1ns/1ps
`default_nettype none
module cf_upstream_src (
  input wire logic pclk,
  output logic in_valid,
  output logic [19:0] in_i,
  output logic [19:0] in_q
);
  initial begin
    in_valid = 1'b0;
    in_i = 20'h0;
    in_q = 20'h0;
  end
  // Idle data toggles so stale values never look valid
  task automatic send(input logic [19:0] i, input logic [19:0] q, input int gap);
    @(posedge pclk);
    in_valid <= 1'b1;
    in_i <= i;
    in_q <= q;
    @(posedge pclk);
    in_valid <= 1'b0;
    repeat (gap) begin
      in_i <= ~in_i;
      in_q <= ~in_q;
      @(posedge pclk);
    end
  endtask : send
endmodule : cf_upstream_src
`default_nettype wire

// [sim/tb.sv]
// Self-checking bench: APB register and port tasks, sample stream tests.
// Assumes the upstream model and the constants header are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
`include "cf_consts.svh"
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, serr, in_valid, out_valid;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [19:0] in_i, in_q, out_i, out_q, lst_i, lst_q;
  int err_count, tests_run, n_out, n0;
  localparam logic [19:0] CA = 20'h10000;
  localparam logic [19:0] CB = 20'h08000;
  localparam logic [19:0] CD = 20'h20000;
  int rt[5] = '{0, 3, 3, 3, 15};
  int ph[5] = '{0, 0, 2, 5, 9};
  int ne[5] = '{16, 4, 4, 0, 1};
  cf_channel_coeff_filter cf_channel_coeff_filter_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .in_valid(in_valid), .in_i(in_i), .in_q(in_q), .out_valid(out_valid),
    .out_i(out_i), .out_q(out_q));
  cf_upstream_src cf_upstream_src_inst (.pclk(pclk), .in_valid(in_valid), .in_i(in_i), .in_q(in_q));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) if (out_valid === 1'b1) begin
    n_out++;
    lst_i = out_i;
    lst_q = out_q;
  end
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Slave latency is not assumed; the wait is bounded
  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_count++;
      $display("[FAIL] %0t no pready", $time);
      tally_and_finish;
    end
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask : wr
  task rdchk(input logic [7:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    chk(rd, e);
  endtask : rdchk
  task wcoef(input logic [19:0] c);
    wr(`CF_OFF_MEM, {16'h0, c[15:0]});
    wr(`CF_OFF_MEM, {28'h0, c[19:16]});
  endtask : wcoef
  task rcoef(input logic [19:0] c);
    rdchk(`CF_OFF_MEM, {16'h0, c[15:0]});
    rdchk(`CF_OFF_MEM, {28'h0, c[19:16]});
  endtask : rcoef
  function logic [31:0] ctl(input logic [3:0] r, p, input logic [1:0] sc, input logic sy, by, nw);
    return {19'h0, nw, by, sy, sc, p, r};
  endfunction : ctl
  function logic [19:0] fx(input longint x, input longint c, input int sh);
    return 20'((x * c) >>> sh);
  endfunction : fx
  // Gap of 12 keeps every run inside the tap budget
  task filt(input logic [31:0] c, input longint cs, input int sh);
    wr(`CF_OFF_CTRL, c);
    repeat (4) cf_upstream_src_inst.send(20'h003e8, 20'h001f4, 12);
    repeat (12) @(posedge pclk);
    chk({12'h0, lst_i}, {12'h0, fx(1000, cs, sh)});
    chk({12'h0, lst_q}, {12'h0, fx(500, cs, sh)});
  endtask : filt
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    err_count = 0;
    tests_run = 0;
    n_out = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(`CF_OFF_CTRL, 32'h0000_0300);
    rdchk(`CF_OFF_TAPS, 32'h0);
    xfer(8'h40, 1'b0, 32'h0);
    chk({31'h0, serr}, 32'h1);
    chk(rd, 32'h0);
    $display("test registers done");
    wr(`CF_OFF_TAPS, 32'h1);
    wr(`CF_OFF_COFS, 32'h0);
    wr(`CF_OFF_CTRL, ctl(0, 0, 3, 0, 0, 0));
    wr(`CF_OFF_START, 32'h0);
    wr(`CF_OFF_STOP, 32'h2);
    wcoef(CA);
    wcoef(CB);
    wcoef(CD);
    wr(`CF_OFF_START, 32'h0);
    rcoef(CA);
    rcoef(CB);
    rcoef(CD);
    rcoef(CA);
    wr(`CF_OFF_CTRL, ctl(0, 0, 3, 0, 0, 1));
    wr(`CF_OFF_START, 32'h5);
    wr(`CF_OFF_STOP, 32'h5);
    wr(`CF_OFF_MEM, 32'h34);
    wr(`CF_OFF_MEM, 32'h12);
    wr(`CF_OFF_MEM, 32'h5);
    wr(`CF_OFF_MEM, 32'hcd);
    wr(`CF_OFF_MEM, 32'hab);
    wr(`CF_OFF_MEM, 32'h0);
    wr(`CF_OFF_START, 32'h5);
    rdchk(`CF_OFF_MEM, 32'hcd);
    rdchk(`CF_OFF_MEM, 32'hab);
    rdchk(`CF_OFF_MEM, 32'h0);
    wr(`CF_OFF_CTRL, ctl(0, 0, 3, 0, 0, 0));
    wr(`CF_OFF_START, 32'h5);
    rcoef(20'h0abcd);
    $display("test coefficient port done");
    for (int k = 0; k < 4; k++) filt(ctl(0, 0, 2'(k), 0, 0, 0), CA + CB, 22 - k);
    wr(`CF_OFF_COFS, 32'h1);
    filt(ctl(0, 0, 3, 0, 0, 0), CB + CD, 19);
    wr(`CF_OFF_TAPS, 32'h3);
    wr(`CF_OFF_CTRL, ctl(0, 0, 3, 1, 0, 0));
    wr(`CF_OFF_COFS, 32'd62);
    wr(`CF_OFF_START, 32'd62);
    wr(`CF_OFF_STOP, 32'h1);
    wcoef(CA);
    wcoef(CB);
    filt(ctl(0, 0, 3, 1, 0, 0), 2 * (CA + CB), 19);
    $display("test filter done");
    wr(`CF_OFF_TAPS, 32'h1);
    for (int k = 0; k < 5; k++) begin
      n0 = n_out;
      wr(`CF_OFF_CTRL, ctl(4'(rt[k]), 4'(ph[k]), 3, 0, 0, 0));
      repeat (16) cf_upstream_src_inst.send(20'h003e8, 20'h001f4, 12);
      repeat (12) @(posedge pclk);
      chk(32'(n_out - n0), 32'(ne[k]));
    end
    $display("test decimation done");
    n0 = n_out;
    wr(`CF_OFF_CTRL, ctl(0, 0, 0, 0, 1, 0));
    cf_upstream_src_inst.send(20'hfedcb, 20'h12345, 12);
    repeat (4) @(posedge pclk);
    chk(32'(n_out - n0), 32'h1);
    chk({12'h0, lst_i}, 32'h000f_edcb);
    chk({12'h0, lst_q}, 32'h0001_2345);
    $display("test bypass done");
    tally_and_finish;
  end
endmodule : tb
`default_nettype wire
